// *** rtl/spcr_top.sv ***
// Loop configuration register bank behind the serial control port
// Behaviour
// - Pre-divider select 00, 01, 10 divides reference by 4, 2, 1.
// - Setup bit 2 of divider control resets 0; bits 7..3 read-only.
// - Oscillator regulator trim resets 0x2B; software writes 0x7B.
// - First power-down trim resets 0x7F; software writes 0x00.
// - First varactor trim resets 0x83; software writes 0x89.
// - Second charge-pump trim resets 0xB0; software writes 0x24.
// - First oscillator trim resets 0x0C; software writes 0x03.
// - Second oscillator trim resets 0x00; software writes 0x0D.
// - Second power-down trim resets 0x00; software writes 0x02.
// - Second varactor trim resets 0xFE; software writes 0x8E.
// - Third charge-pump trim resets 0x17; software writes 0x2A.
// - Third varactor trim resets 0x33; software writes 0x78.
// - Fourth varactor trim resets 0x08; software writes 0x06.
// - Clock setup byte resets 0x4B; software writes 0xFF.
// - Setting loop enable enables the loop and starts calibration.
`timescale 1ns/1ps
`default_nettype none
`include "spcr_defines.svh"
module spcr_top
    import spcr_pkg::*;
(
    input wire logic CLK,
    input wire logic RESETN,
    input wire logic CS_N,
    input wire logic SCLK,
    input wire logic SDIO_IN,
    input wire logic REF_CLK_IN,
    output logic SDO,
    output logic SDO_OE,
    output logic [1:0] REF_PREDIV_SELECT,
    output logic PLL_SETUP_BIT,
    output logic [7:0] OSCILLATOR_REGULATOR_TRIM,
    output logic [7:0] LOOP_POWERDOWN_TRIM_A,
    output logic [7:0] VARACTOR_TRIM_A,
    output logic [7:0] CHARGE_PUMP_TRIM_B,
    output logic [7:0] OSCILLATOR_TRIM_A,
    output logic [7:0] OSCILLATOR_TRIM_B,
    output logic [7:0] LOOP_POWERDOWN_TRIM_B,
    output logic [7:0] VARACTOR_TRIM_B,
    output logic [7:0] CHARGE_PUMP_TRIM_C,
    output logic [7:0] VARACTOR_TRIM_C,
    output logic [7:0] VARACTOR_TRIM_D,
    output logic [7:0] CLOCK_SETUP,
    output logic LOOP_ENABLE,
    output logic CAL_START,
    output logic PFD_REF_TICK
);
    spcr_byte_t regs [`SPCR_NREG];
    logic [14:0] addr;
    logic [7:0] wdata;
    logic wr_stb;
    logic [7:0] rdata;
    logic [4:0] look;
    logic hit;
    logic [3:0] idx;
    logic next_cal;

    // Address decode: hit flag and storage index
    function automatic logic [4:0] index_of(input logic [14:0] a);
        case (a)
            `SPCR_A_LOOP_CTRL: index_of = {1'b1, `SPCR_I_LOOP_CTRL};
            `SPCR_A_REF_DIV: index_of = {1'b1, `SPCR_I_REF_DIV};
            `SPCR_A_OSC_REG: index_of = {1'b1, `SPCR_I_OSC_REG};
            `SPCR_A_PD_A: index_of = {1'b1, `SPCR_I_PD_A};
            `SPCR_A_VAR_A: index_of = {1'b1, `SPCR_I_VAR_A};
            `SPCR_A_CP_B: index_of = {1'b1, `SPCR_I_CP_B};
            `SPCR_A_OSC_A: index_of = {1'b1, `SPCR_I_OSC_A};
            `SPCR_A_OSC_B: index_of = {1'b1, `SPCR_I_OSC_B};
            `SPCR_A_PD_B: index_of = {1'b1, `SPCR_I_PD_B};
            `SPCR_A_VAR_B: index_of = {1'b1, `SPCR_I_VAR_B};
            `SPCR_A_CP_C: index_of = {1'b1, `SPCR_I_CP_C};
            `SPCR_A_VAR_C: index_of = {1'b1, `SPCR_I_VAR_C};
            `SPCR_A_VAR_D: index_of = {1'b1, `SPCR_I_VAR_D};
            `SPCR_A_CLK_SETUP: index_of = {1'b1, `SPCR_I_CLK_SETUP};
            default: index_of = 5'h00;
        endcase
    endfunction

    // Reset value of each stored byte
    function automatic spcr_byte_t reset_of(input logic [3:0] i);
        case (i)
            `SPCR_I_LOOP_CTRL: reset_of = `SPCR_R_LOOP_CTRL;
            `SPCR_I_REF_DIV: reset_of = `SPCR_R_REF_DIV;
            `SPCR_I_OSC_REG: reset_of = `SPCR_R_OSC_REG;
            `SPCR_I_PD_A: reset_of = `SPCR_R_PD_A;
            `SPCR_I_VAR_A: reset_of = `SPCR_R_VAR_A;
            `SPCR_I_CP_B: reset_of = `SPCR_R_CP_B;
            `SPCR_I_OSC_A: reset_of = `SPCR_R_OSC_A;
            `SPCR_I_OSC_B: reset_of = `SPCR_R_OSC_B;
            `SPCR_I_PD_B: reset_of = `SPCR_R_PD_B;
            `SPCR_I_VAR_B: reset_of = `SPCR_R_VAR_B;
            `SPCR_I_CP_C: reset_of = `SPCR_R_CP_C;
            `SPCR_I_VAR_C: reset_of = `SPCR_R_VAR_C;
            `SPCR_I_VAR_D: reset_of = `SPCR_R_VAR_D;
            `SPCR_I_CLK_SETUP: reset_of = `SPCR_R_CLK_SETUP;
            default: reset_of = 8'h00;
        endcase
    endfunction

    // Writable bits of each stored byte; reserved bits stay zero
    function automatic spcr_byte_t mask_of(input logic [3:0] i);
        case (i)
            `SPCR_I_LOOP_CTRL: mask_of = `SPCR_M_LOOP_CTRL;
            `SPCR_I_REF_DIV: mask_of = `SPCR_M_REF_DIV;
            default: mask_of = (i < 4'(`SPCR_NREG)) ? `SPCR_M_FULL : `SPCR_M_NONE;
        endcase
    endfunction

    spcr_spi_port u_port (
        .clk(CLK),
        .rst_n(RESETN),
        .cs_n_pin(CS_N),
        .sclk_pin(SCLK),
        .sdi_pin(SDIO_IN),
        .rdata(rdata),
        .addr(addr),
        .wdata(wdata),
        .wr_stb(wr_stb),
        .sdo(SDO),
        .sdo_oe(SDO_OE)
    );

    // Decode of the port's current address, shared by read and write
    always_comb begin
        look = index_of(addr);
        hit = look[4];
        idx = look[3:0];
        rdata = hit ? regs[idx] : 8'h00;
    end

    // One byte of storage per register, write masked by its writable bits
    for (genvar i = 0; i < `SPCR_NREG; i++) begin : g_reg
        spcr_byte_t next_val;
        always_comb begin
            next_val = regs[i];
            if (wr_stb && hit && idx == 4'(i)) begin
                next_val = wdata & mask_of(4'(i));
            end
        end
        always_ff @(posedge CLK or negedge RESETN) begin
            if (!RESETN) begin
                regs[i] <= reset_of(4'(i));
            end else begin
                regs[i] <= next_val;
            end
        end
    end

    // Calibration start on a 0 to 1 write of the loop enable bit
    always_comb begin
        next_cal = wr_stb && hit && idx == `SPCR_I_LOOP_CTRL
            && wdata[`SPCR_BIT_LOOP_EN]
            && !regs[`SPCR_I_LOOP_CTRL][`SPCR_BIT_LOOP_EN];
    end

    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            CAL_START <= 1'b0;
        end else begin
            CAL_START <= next_cal;
        end
    end

    spcr_prediv u_prediv (
        .clk(CLK),
        .rst_n(RESETN),
        .ref_pin(REF_CLK_IN),
        .sel(regs[`SPCR_I_REF_DIV][`SPCR_PREDIV_HI:`SPCR_PREDIV_LO]),
        .tick(PFD_REF_TICK)
    );

    // Configuration outputs taken straight from the storage flip-flops
    assign REF_PREDIV_SELECT = regs[`SPCR_I_REF_DIV][`SPCR_PREDIV_HI:`SPCR_PREDIV_LO];
    assign PLL_SETUP_BIT = regs[`SPCR_I_REF_DIV][`SPCR_BIT_SETUP];
    assign OSCILLATOR_REGULATOR_TRIM = regs[`SPCR_I_OSC_REG];
    assign LOOP_POWERDOWN_TRIM_A = regs[`SPCR_I_PD_A];
    assign VARACTOR_TRIM_A = regs[`SPCR_I_VAR_A];
    assign CHARGE_PUMP_TRIM_B = regs[`SPCR_I_CP_B];
    assign OSCILLATOR_TRIM_A = regs[`SPCR_I_OSC_A];
    assign OSCILLATOR_TRIM_B = regs[`SPCR_I_OSC_B];
    assign LOOP_POWERDOWN_TRIM_B = regs[`SPCR_I_PD_B];
    assign VARACTOR_TRIM_B = regs[`SPCR_I_VAR_B];
    assign CHARGE_PUMP_TRIM_C = regs[`SPCR_I_CP_C];
    assign VARACTOR_TRIM_C = regs[`SPCR_I_VAR_C];
    assign VARACTOR_TRIM_D = regs[`SPCR_I_VAR_D];
    assign CLOCK_SETUP = regs[`SPCR_I_CLK_SETUP];
    assign LOOP_ENABLE = regs[`SPCR_I_LOOP_CTRL][`SPCR_BIT_LOOP_EN];
endmodule
`default_nettype wire

// *** rtl/spcr_defines.svh ***
// Offsets, reset values, masks and timing constants of the loop configuration bank
`ifndef SPCR_DEFINES_SVH
`define SPCR_DEFINES_SVH

`define SPCR_ADDR_W 15
`define SPCR_DATA_W 8
`define SPCR_NREG 14
`define SPCR_IDX_W 4
`define SPCR_INSTR_BITS 5'h10
`define SPCR_FRAME_BITS 5'h18
`define SPCR_LAST_BIT 5'h17

// Byte addresses
`define SPCR_A_LOOP_CTRL 15'h0280
`define SPCR_A_REF_DIV 15'h0289
`define SPCR_A_OSC_REG 15'h028a
`define SPCR_A_PD_A 15'h028b
`define SPCR_A_VAR_A 15'h0290
`define SPCR_A_CP_B 15'h0294
`define SPCR_A_OSC_A 15'h0296
`define SPCR_A_OSC_B 15'h0297
`define SPCR_A_PD_B 15'h0299
`define SPCR_A_VAR_B 15'h029a
`define SPCR_A_CP_C 15'h029c
`define SPCR_A_VAR_C 15'h029f
`define SPCR_A_VAR_D 15'h02a0
`define SPCR_A_CLK_SETUP 15'h02a4

// Storage indices
`define SPCR_I_LOOP_CTRL 4'h0
`define SPCR_I_REF_DIV 4'h1
`define SPCR_I_OSC_REG 4'h2
`define SPCR_I_PD_A 4'h3
`define SPCR_I_VAR_A 4'h4
`define SPCR_I_CP_B 4'h5
`define SPCR_I_OSC_A 4'h6
`define SPCR_I_OSC_B 4'h7
`define SPCR_I_PD_B 4'h8
`define SPCR_I_VAR_B 4'h9
`define SPCR_I_CP_C 4'ha
`define SPCR_I_VAR_C 4'hb
`define SPCR_I_VAR_D 4'hc
`define SPCR_I_CLK_SETUP 4'hd

// Reset values
`define SPCR_R_LOOP_CTRL 8'h00
`define SPCR_R_REF_DIV 8'h00
`define SPCR_R_OSC_REG 8'h2b
`define SPCR_R_PD_A 8'h7f
`define SPCR_R_VAR_A 8'h83
`define SPCR_R_CP_B 8'hb0
`define SPCR_R_OSC_A 8'h0c
`define SPCR_R_OSC_B 8'h00
`define SPCR_R_PD_B 8'h00
`define SPCR_R_VAR_B 8'hfe
`define SPCR_R_CP_C 8'h17
`define SPCR_R_VAR_C 8'h33
`define SPCR_R_VAR_D 8'h08
`define SPCR_R_CLK_SETUP 8'h4b

// Writable bit masks
`define SPCR_M_LOOP_CTRL 8'h01
`define SPCR_M_REF_DIV 8'h07
`define SPCR_M_FULL 8'hff
`define SPCR_M_NONE 8'h00

// Field positions
`define SPCR_BIT_LOOP_EN 0
`define SPCR_BIT_SETUP 2
`define SPCR_PREDIV_HI 1
`define SPCR_PREDIV_LO 0

// Pre-divider select codes and their division counts minus one
`define SPCR_DIV_BY4 2'h0
`define SPCR_DIV_BY2 2'h1
`define SPCR_DIV_BY1 2'h2
`define SPCR_LIM_BY4 2'h3
`define SPCR_LIM_BY2 2'h1
`define SPCR_LIM_BY1 2'h0

`endif

// *** rtl/spcr_pkg.sv ***
// Types shared by the loop configuration bank
package spcr_pkg;
    typedef enum logic [1:0] {SPCR_IDLE, SPCR_INSTR, SPCR_DATA} spcr_port_state_t;
    typedef logic [7:0] spcr_byte_t;
endpackage

// *** rtl/spcr_prediv.sv ***
// Reference clock pre-divider feeding the phase detector
`timescale 1ns/1ps
`default_nettype none
`include "spcr_defines.svh"
module spcr_prediv
    import spcr_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ref_pin,
    input wire logic [1:0] sel,
    output logic tick
);
    logic ref_s1;
    logic ref_s2;
    logic ref_s3;
    logic [1:0] cnt;
    logic [1:0] next_cnt;
    logic next_tick;
    logic [1:0] limit;

    // Division count chosen by the select code; unused code divides by 4
    always_comb begin
        case (sel)
            `SPCR_DIV_BY2: limit = `SPCR_LIM_BY2;
            `SPCR_DIV_BY1: limit = `SPCR_LIM_BY1;
            default: limit = `SPCR_LIM_BY4;
        endcase
    end

    // Count reference rising edges, one tick per divided period
    always_comb begin
        next_cnt = cnt;
        next_tick = 1'b0;
        if (ref_s2 && !ref_s3) begin
            if (cnt >= limit) begin
                next_cnt = 2'h0;
                next_tick = 1'b1;
            end else begin
                next_cnt = cnt + 2'h1;
            end
        end
    end

    // Synchroniser, edge history and divider state
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ref_s1 <= 1'b0;
            ref_s2 <= 1'b0;
            ref_s3 <= 1'b0;
            cnt <= 2'h0;
            tick <= 1'b0;
        end else begin
            ref_s1 <= ref_pin;
            ref_s2 <= ref_s1;
            ref_s3 <= ref_s2;
            cnt <= next_cnt;
            tick <= next_tick;
        end
    end
endmodule
`default_nettype wire

// *** rtl/spcr_spi_port.sv ***
// Serial control port slave: 16-bit instruction then one data byte
`timescale 1ns/1ps
`default_nettype none
`include "spcr_defines.svh"
module spcr_spi_port
    import spcr_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic cs_n_pin,
    input wire logic sclk_pin,
    input wire logic sdi_pin,
    input wire logic [7:0] rdata,
    output logic [14:0] addr,
    output logic [7:0] wdata,
    output logic wr_stb,
    output logic sdo,
    output logic sdo_oe
);
    logic [2:0] s1;
    logic [2:0] s2;
    logic sclk_d;
    spcr_port_state_t state;
    spcr_port_state_t next_state;
    logic [4:0] cnt;
    logic [4:0] next_cnt;
    logic [15:0] sr;
    logic [15:0] next_sr;
    logic is_read;
    logic next_is_read;
    logic [14:0] next_addr;
    logic [7:0] next_wdata;
    logic next_wr_stb;
    logic next_sdo;
    logic next_sdo_oe;
    logic cs_act;
    logic rise;
    logic fall;

    assign cs_act = !s2[2];
    assign rise = s2[1] && !sclk_d;
    assign fall = !s2[1] && sclk_d;

    // Frame sequencer: shift on SCLK rise, drive read data on SCLK fall
    always_comb begin
        next_state = state;
        next_cnt = cnt;
        next_sr = sr;
        next_is_read = is_read;
        next_addr = addr;
        next_wdata = wdata;
        next_wr_stb = 1'b0;
        next_sdo = sdo;
        next_sdo_oe = sdo_oe;
        if (!cs_act) begin
            next_state = SPCR_IDLE;
            next_cnt = 5'h0;
            next_sdo_oe = 1'b0;
        end else begin
            case (state)
                SPCR_IDLE: begin
                    next_state = SPCR_INSTR;
                    next_cnt = 5'h0;
                end
                SPCR_INSTR: begin
                    if (rise) begin
                        next_sr = {sr[14:0], s2[0]};
                        next_cnt = cnt + 5'h1;
                        if (cnt + 5'h1 == `SPCR_INSTR_BITS) begin
                            next_is_read = sr[14];
                            next_addr = {sr[13:0], s2[0]};
                            next_state = SPCR_DATA;
                        end
                    end
                end
                SPCR_DATA: begin
                    if (rise && cnt != `SPCR_FRAME_BITS) begin
                        next_sr = {sr[14:0], s2[0]};
                        next_cnt = cnt + 5'h1;
                        if (cnt == `SPCR_LAST_BIT && !is_read) begin
                            next_wdata = {sr[6:0], s2[0]};
                            next_wr_stb = 1'b1;
                        end
                    end
                    if (fall && is_read && cnt != `SPCR_FRAME_BITS) begin
                        next_sdo = rdata[3'(`SPCR_LAST_BIT - cnt)];
                        next_sdo_oe = 1'b1;
                    end
                end
                default: next_state = SPCR_IDLE;
            endcase
        end
    end

    // Pin synchronisers and frame state
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s1 <= 3'h4;
            s2 <= 3'h4;
            sclk_d <= 1'b0;
            state <= SPCR_IDLE;
            cnt <= 5'h0;
            sr <= 16'h0000;
            is_read <= 1'b0;
            addr <= 15'h0000;
            wdata <= 8'h00;
            wr_stb <= 1'b0;
            sdo <= 1'b0;
            sdo_oe <= 1'b0;
        end else begin
            s1 <= {cs_n_pin, sclk_pin, sdi_pin};
            s2 <= s1;
            sclk_d <= s2[1];
            state <= next_state;
            cnt <= next_cnt;
            sr <= next_sr;
            is_read <= next_is_read;
            addr <= next_addr;
            wdata <= next_wdata;
            wr_stb <= next_wr_stb;
            sdo <= next_sdo;
            sdo_oe <= next_sdo_oe;
        end
    end
endmodule
`default_nettype wire

// *** verification/spcr_top_monitor.sv ***
// Port-level checks of the loop configuration bank
`timescale 1ns/1ps
`default_nettype none
module spcr_top_monitor (
    input wire logic CLK,
    input wire logic RESETN,
    input wire logic CS_N,
    input wire logic REF_CLK_IN,
    input wire logic SDO_OE,
    input wire logic [1:0] REF_PREDIV_SELECT,
    input wire logic PLL_SETUP_BIT,
    input wire logic [7:0] OSCILLATOR_REGULATOR_TRIM,
    input wire logic [7:0] LOOP_POWERDOWN_TRIM_A,
    input wire logic [7:0] VARACTOR_TRIM_A,
    input wire logic [7:0] CHARGE_PUMP_TRIM_C,
    input wire logic [7:0] VARACTOR_TRIM_C,
    input wire logic [7:0] CLOCK_SETUP,
    input wire logic LOOP_ENABLE,
    input wire logic CAL_START,
    input wire logic PFD_REF_TICK
);
    logic ref_q;
    logic cnt_ok;
    logic [1:0] sel_q;
    logic [2:0] ref_cnt;
    logic [2:0] fac;
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RESETN);
    // Expected reference edges per tick for the current select code
    assign fac = (REF_PREDIV_SELECT == 2'h1) ? 3'h2 : (REF_PREDIV_SELECT == 2'h2) ? 3'h1 : 3'h4;
    // Counts reference rises between ticks; first tick after a code change is skipped
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            ref_q <= 1'b0;
            sel_q <= 2'h0;
            cnt_ok <= 1'b0;
            ref_cnt <= 3'h0;
        end else begin
            ref_q <= REF_CLK_IN;
            sel_q <= REF_PREDIV_SELECT;
            if (sel_q != REF_PREDIV_SELECT) cnt_ok <= 1'b0;
            else if (PFD_REF_TICK) cnt_ok <= 1'b1;
            if (PFD_REF_TICK) ref_cnt <= {2'h0, REF_CLK_IN & !ref_q};
            else if (REF_CLK_IN & !ref_q) ref_cnt <= ref_cnt + 3'h1;
        end
    end
    // Port quiet long enough that no write can still be in flight
    sequence cs_idle;
        CS_N [*8];
    endsequence
    rst_trims_a: assert property (
        $rose(RESETN) |-> OSCILLATOR_REGULATOR_TRIM == 8'h2b && LOOP_POWERDOWN_TRIM_A == 8'h7f
        && VARACTOR_TRIM_A == 8'h83) else $error("trim reset value wrong");
    rst_loop_trims_a: assert property (
        $rose(RESETN) |-> CHARGE_PUMP_TRIM_C == 8'h17 && VARACTOR_TRIM_C == 8'h33
        && CLOCK_SETUP == 8'h4b) else $error("trim reset value wrong");
    rst_ctrl_a: assert property (
        $rose(RESETN) |-> {LOOP_ENABLE, PLL_SETUP_BIT, REF_PREDIV_SELECT} == 4'h0)
        else $error("control reset value wrong");
    cal_pulse_a: assert property (CAL_START |=> !CAL_START)
        else $error("calibration start too long");
    cal_enable_a: assert property (CAL_START |-> ##[0:1] LOOP_ENABLE)
        else $error("calibration without enable");
    tick_pulse_a: assert property (PFD_REF_TICK |=> !PFD_REF_TICK)
        else $error("tick too long");
    tick_ratio_a: assert property (PFD_REF_TICK && cnt_ok |-> ref_cnt == fac)
        else $error("tick ratio wrong");
    trim_hold_a: assert property (
        cs_idle |=> $stable({OSCILLATOR_REGULATOR_TRIM, VARACTOR_TRIM_A, CLOCK_SETUP,
        LOOP_ENABLE, PLL_SETUP_BIT, REF_PREDIV_SELECT})) else $error("value changed while idle");
    oe_idle_a: assert property (cs_idle |-> !SDO_OE)
        else $error("output driven while idle");
endmodule
bind spcr_top spcr_top_monitor i_spcr_top_monitor (.*);
`default_nettype wire

// *** verification/tb_spcr_top.sv ***
// Self-checking bench for the loop configuration bank
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin n_compared++; if ((s) !== (e)) begin error_cnt++; \
    $display("Error %s expected %h seen %h", n, e, s); end end
module tb_spcr_top;
    logic clk = 1'b0, resetn = 1'b0, cs_n = 1'b1, sclk = 1'b0, sdi = 1'b0, ref_clk = 1'b0;
    wire sdo, sdo_oe, setup, le, cal, tick;
    wire [1:0] psel;
    wire [7:0] tr [2:13];
    int error_cnt = 0, n_compared = 0, cal_cnt = 0, tick_cnt = 0;
    logic [31:0] s = 32'h0a51fcb1;
    logic [7:0] q;
    logic [7:0] mdl [14];
    logic [14:0] adr [14] = '{15'h280, 15'h289, 15'h28a, 15'h28b, 15'h290, 15'h294, 15'h296,
        15'h297, 15'h299, 15'h29a, 15'h29c, 15'h29f, 15'h2a0, 15'h2a4};
    logic [7:0] rsv [14] = '{8'h00, 8'h00, 8'h2b, 8'h7f, 8'h83, 8'hb0, 8'h0c, 8'h00, 8'h00,
        8'hfe, 8'h17, 8'h33, 8'h08, 8'h4b};
    logic [7:0] prg [14] = '{8'h00, 8'h04, 8'h7b, 8'h00, 8'h89, 8'h24, 8'h03, 8'h0d, 8'h02,
        8'h8e, 8'h2a, 8'h78, 8'h06, 8'hff};
    spcr_top i_spcr_top (.CLK(clk), .RESETN(resetn), .CS_N(cs_n), .SCLK(sclk), .SDIO_IN(sdi),
        .REF_CLK_IN(ref_clk), .SDO(sdo), .SDO_OE(sdo_oe), .REF_PREDIV_SELECT(psel),
        .PLL_SETUP_BIT(setup), .OSCILLATOR_REGULATOR_TRIM(tr[2]), .LOOP_POWERDOWN_TRIM_A(tr[3]),
        .VARACTOR_TRIM_A(tr[4]), .CHARGE_PUMP_TRIM_B(tr[5]), .OSCILLATOR_TRIM_A(tr[6]),
        .OSCILLATOR_TRIM_B(tr[7]), .LOOP_POWERDOWN_TRIM_B(tr[8]), .VARACTOR_TRIM_B(tr[9]),
        .CHARGE_PUMP_TRIM_C(tr[10]), .VARACTOR_TRIM_C(tr[11]), .VARACTOR_TRIM_D(tr[12]),
        .CLOCK_SETUP(tr[13]), .LOOP_ENABLE(le), .CAL_START(cal), .PFD_REF_TICK(tick));
    // Clock, and a reference at one tenth of it
    always #10 clk = ~clk;
    always begin
        repeat (5) @(posedge clk);
        ref_clk <= ~ref_clk;
    end
    // Pulse counters
    always @(posedge clk) begin
        if (cal === 1'b1) cal_cnt++;
        if (tick === 1'b1) tick_cnt++;
    end
    function automatic logic [31:0] nx(input logic [31:0] v);
        return {v[30:0], 1'b0} ^ (v[31] ? 32'h04c11db7 : 32'h0);
    endfunction
    function automatic logic [7:0] pv(input int i);
        if (i == 0) return {7'h00, le};
        if (i == 1) return {5'h00, setup, psel};
        return tr[i];
    endfunction
    // One frame of n bits: read or write flag, address, data; read byte returned in r
    task automatic xfer(input logic rd, input logic [14:0] a, input logic [7:0] d, input int n,
        output logic [7:0] r);
        logic [23:0] f;
        f = {rd, a, d};
        r = 8'h00;
        @(posedge clk);
        cs_n <= 1'b0;
        repeat (4) @(posedge clk);
        for (int k = 23; k >= 24 - n; k--) begin
            sdi <= f[k];
            repeat (4) @(posedge clk);
            sclk <= 1'b1;
            if (k < 8) begin
                r = {r[6:0], sdo};
                if (rd) `CHK("sdo_oe", 1'b1, sdo_oe)
            end
            repeat (4) @(posedge clk);
            sclk <= 1'b0;
        end
        repeat (8) @(posedge clk);
        cs_n <= 1'b1;
        sdi <= ~sdi;
        repeat (8) @(posedge clk);
    endtask
    task automatic wr(input int i, input logic [7:0] d);
        logic [7:0] r;
        xfer(1'b0, adr[i], d, 24, r);
        mdl[i] = d & ((i == 0) ? 8'h01 : (i == 1) ? 8'h07 : 8'hff);
    endtask
    task automatic chk(input int i);
        logic [7:0] r;
        xfer(1'b1, adr[i], 8'h00, 24, r);
        `CHK("read", mdl[i], r)
        `CHK("port", mdl[i], pv(i))
    endtask
    task automatic do_reset();
        resetn <= 1'b0;
        repeat (2) @(posedge clk);
        resetn <= 1'b1;
        foreach (mdl[i]) mdl[i] = rsv[i];
        repeat (3) @(posedge clk);
        for (int i = 0; i < 14; i++) chk(i);
        $display("reset values done");
    endtask
    task automatic stop_test();
        $display("compared %0d mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    initial begin
        repeat (60000) @(posedge clk);
        error_cnt++;
        stop_test();
    end
    initial begin
        int i, n0, f;
        do_reset();
        // Unmapped place and reserved bits
        xfer(1'b0, 15'h2a5, 8'hff, 24, q);
        xfer(1'b1, 15'h2a5, 8'h00, 24, q);
        `CHK("unmapped", 8'h00, q)
        wr(1, 8'hff);
        chk(1);
        $display("reserved done");
        // Programmed values
        for (i = 1; i < 14; i++) begin
            wr(i, prg[i]);
            chk(i);
        end
        $display("programmed done");
        // Calibration start only on a 0 to 1 write
        n0 = cal_cnt;
        wr(0, 8'h01);
        wr(0, 8'hff);
        wr(0, 8'hfe);
        wr(0, 8'h01);
        chk(0);
        `CHK("cal_start", n0 + 2, cal_cnt)
        // Aborted frame leaves the register alone
        xfer(1'b0, adr[2], 8'h55, 20, q);
        chk(2);
        $display("control done");
        // Random writes
        repeat (24) begin
            s = nx(s);
            i = int'(s[7:0]) % 14;
            wr(i, s[15:8]);
            chk(i);
        end
        $display("random done");
        // Pre-divider ratios, every code
        for (int c = 0; c < 4; c++) begin
            wr(1, {6'h01, c[1:0]});
            f = (c == 1) ? 2 : (c == 2) ? 1 : 4;
            repeat (100) @(posedge clk);
            n0 = 0;
            while (tick !== 1'b1 && n0 < 60) begin
                @(posedge clk);
                n0++;
            end
            // A tick that never comes is a mismatch of its own
            if (n0 >= 60) error_cnt++;
            @(negedge clk);
            n0 = tick_cnt;
            repeat (165) @(posedge clk);
            @(negedge clk);
            `CHK("ticks", 16 / f, tick_cnt - n0)
        end
        $display("divider done");
        do_reset();
        stop_test();
    end
endmodule
`default_nettype wire
